// ===== rtl/svm_pkg.sv
package svm_pkg;
	// Register byte offsets
	localparam logic [5:0] OFS_CTRL      = 6'h00;
	localparam logic [5:0] OFS_PPR       = 6'h04;
	localparam logic [5:0] OFS_AT_RANGE  = 6'h08;
	localparam logic [5:0] OFS_CM_RANGE  = 6'h0C;
	localparam logic [5:0] OFS_TQ_FWD    = 6'h10;
	localparam logic [5:0] OFS_TQ_REV    = 6'h14;
	localparam logic [5:0] OFS_TQ_INT2   = 6'h18;
	localparam logic [5:0] OFS_STATUS    = 6'h1C;
	localparam logic [5:0] OFS_REV_POS   = 6'h20;

	// CTRL field positions
	localparam int CTRL_PHASE_DIR_BIT = 0;

	// STATUS field positions
	localparam int ST_FINISHED_BIT = 0;
	localparam int ST_COARSE_BIT   = 1;
	localparam int ST_AT_TGT_BIT   = 2;
	localparam int ST_BUSY_BIT     = 3;
	localparam int ST_LIMIT_BIT    = 4;
	localparam int ST_SERVO_ON_BIT = 5;
	localparam int ST_MAINS_BIT    = 6;

	// Values after reset
	localparam logic [15:0] PPR_RST      = 16'h0FA0;
	localparam logic [31:0] AT_RANGE_RST = 32'h0000_0064;
	localparam logic [31:0] CM_RANGE_RST = 32'h0000_0000;
	localparam logic [15:0] TQ_LIMIT_RST = 16'h03E8;

	// Timing
	localparam int CLK_HZ          = 100_000_000;
	localparam int INDEX_MIN_US    = 400;
	localparam int INDEX_MIN_CYC   = (INDEX_MIN_US * (CLK_HZ / 1_000_000));
	localparam int START_MAX_MS    = 3;
	localparam int START_MAX_CYC   = (START_MAX_MS * (CLK_HZ / 1_000));
	localparam int OTHER_MAX_MS    = 10;
	localparam int START_HOLD_MS   = 6;

	// Synchronised input lanes
	localparam int DIN_FWD   = 0;
	localparam int DIN_REV   = 1;
	localparam int DIN_PAUSE = 2;
	localparam int DIN_TSEL  = 3;
	localparam int DIN_EMG   = 4;
	localparam int DIN_MAINS = 5;
	localparam int DIN_SON   = 6;
	localparam int DIN_ALARM = 7;
	localparam int DIN_W     = 8;

	typedef enum logic [1:0] {
		SVM_IDLE,
		SVM_MOVING,
		SVM_HALTED
	} svm_state_t;
endpackage

// ===== rtl/svm_din_if.sv
`timescale 1ns/1ps
`default_nettype none
interface svm_din_if #(parameter int W = 8);
	logic [W-1:0] raw;
	logic [W-1:0] level;
	logic [W-1:0] rise;
	modport sync (input raw, output level, output rise);
	modport user (output raw, input level, input rise);
endinterface
`default_nettype wire

// ===== rtl/svm_din_sync.sv
`timescale 1ns/1ps
`default_nettype none
module svm_din_sync #(
	parameter int W = 8
) (
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	svm_din_if.sync   din
);
	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;
	logic [W-1:0] prev_r;

	// First stage feeds only the second stage
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			meta_r <= '0;
			sync_r <= '0;
			prev_r <= '0;
		end else begin
			meta_r <= din.raw;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign din.level = sync_r;
	// One pulse per off-to-on change of the settled level
	assign din.rise  = sync_r & ~prev_r;
endmodule // svm_din_sync
`default_nettype wire

// ===== rtl/svm_motion_io.sv
`timescale 1ns/1ps
`default_nettype none
module svm_motion_io #(
	parameter int FB_COUNTS_PER_REV = 131072,
	parameter int INDEX_CYCLES      = svm_pkg::INDEX_MIN_CYC
) (
	// Clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	// Avalon-MM slave
	input  wire logic [5:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	// Fieldbus and pin inputs
	input  wire logic        forward_start_cmd_i,
	input  wire logic        reverse_start_cmd_i,
	input  wire logic        pause_resume_cmd_i,
	input  wire logic        torque_limit_select_in_i,
	input  wire logic        emergency_halt_in_i,
	input  wire logic        main_power_ok_i,
	input  wire logic        servo_on_i,
	input  wire logic        alarm_i,
	// Motion core, same clock
	input  wire logic        fb_step_i,
	input  wire logic        fb_dir_ccw_i,
	input  wire logic [31:0] pos_cmd_i,
	input  wire logic [31:0] pos_target_i,
	input  wire logic [31:0] pos_fb_i,
	input  wire logic        cmd_done_i,
	input  wire logic [15:0] torque_demand_i,
	// Motion core commands
	output logic             move_start_fwd_o,
	output logic             move_start_rev_o,
	output logic             pause_resume_o,
	output logic      [15:0] torque_out_o,
	// Encoder emulation outputs
	output logic             enc_phase_a_pos_o,
	output logic             enc_phase_a_neg_o,
	output logic             enc_phase_b_pos_o,
	output logic             enc_phase_b_neg_o,
	output logic             enc_index_pos_o,
	output logic             enc_index_neg_o,
	// Status outputs
	output logic             motion_finished_out_o,
	output logic             coarse_match_out_o,
	output logic             at_target_flag_o,
	output logic             torque_limiting_out_o
);
	localparam logic [32:0] FB_CNT   = 33'(FB_COUNTS_PER_REV);
	localparam logic [31:0] IDX_LOAD = 32'(INDEX_CYCLES);

	svm_din_if #(.W(svm_pkg::DIN_W)) din ();

	assign din.raw = {alarm_i, servo_on_i, main_power_ok_i, emergency_halt_in_i,
		torque_limit_select_in_i, pause_resume_cmd_i, reverse_start_cmd_i,
		forward_start_cmd_i};

	svm_din_sync #(.W(svm_pkg::DIN_W)) u_sync (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.din       (din)
	);

	logic servo_on;
	logic mains_ok;
	logic abort;
	assign servo_on = din.level[svm_pkg::DIN_SON];
	assign mains_ok = din.level[svm_pkg::DIN_MAINS];
	assign abort    = ~servo_on | din.level[svm_pkg::DIN_EMG] | din.level[svm_pkg::DIN_ALARM];

	// Configuration registers
	logic        phase_direction_cfg_r;
	logic [15:0] pulses_per_rev_cfg_r;
	logic [31:0] at_target_range_cfg_r;
	logic [31:0] coarse_match_range_cfg_r;
	logic [15:0] fwd_torque_limit_cfg_r;
	logic [15:0] rev_torque_limit_cfg_r;
	logic [15:0] internal_torque_limit2_cfg_r;

	// Avalon slave: one wait state per access
	logic        bus_req;
	logic        bus_take;
	logic [31:0] rd_nxt;
	logic [6:0]  status;
	logic [32:0] rev_pos_r;

	assign bus_req  = avs_read_i | avs_write_i;
	assign bus_take = bus_req & ~avs_waitrequest_o;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			avs_waitrequest_o <= 1'b1;
		end else begin
			avs_waitrequest_o <= ~(bus_req & avs_waitrequest_o);
		end
	end

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			phase_direction_cfg_r        <= 1'b0;
			pulses_per_rev_cfg_r         <= svm_pkg::PPR_RST;
			at_target_range_cfg_r        <= svm_pkg::AT_RANGE_RST;
			coarse_match_range_cfg_r     <= svm_pkg::CM_RANGE_RST;
			fwd_torque_limit_cfg_r       <= svm_pkg::TQ_LIMIT_RST;
			rev_torque_limit_cfg_r       <= svm_pkg::TQ_LIMIT_RST;
			internal_torque_limit2_cfg_r <= svm_pkg::TQ_LIMIT_RST;
		end else if (bus_take && avs_write_i) begin
			unique case (avs_address_i)
				svm_pkg::OFS_CTRL: begin
					if (avs_byteenable_i[0]) begin
						phase_direction_cfg_r <= avs_writedata_i[svm_pkg::CTRL_PHASE_DIR_BIT];
					end
				end
				svm_pkg::OFS_PPR: begin
					pulses_per_rev_cfg_r <= 16'(merge({16'h0000, pulses_per_rev_cfg_r},
						avs_writedata_i, avs_byteenable_i));
				end
				svm_pkg::OFS_AT_RANGE: begin
					at_target_range_cfg_r <= merge(at_target_range_cfg_r,
						avs_writedata_i, avs_byteenable_i);
				end
				svm_pkg::OFS_CM_RANGE: begin
					coarse_match_range_cfg_r <= merge(coarse_match_range_cfg_r,
						avs_writedata_i, avs_byteenable_i);
				end
				svm_pkg::OFS_TQ_FWD: begin
					fwd_torque_limit_cfg_r <= 16'(merge({16'h0000, fwd_torque_limit_cfg_r},
						avs_writedata_i, avs_byteenable_i));
				end
				svm_pkg::OFS_TQ_REV: begin
					rev_torque_limit_cfg_r <= 16'(merge({16'h0000, rev_torque_limit_cfg_r},
						avs_writedata_i, avs_byteenable_i));
				end
				svm_pkg::OFS_TQ_INT2: begin
					internal_torque_limit2_cfg_r <= 16'(merge(
						{16'h0000, internal_torque_limit2_cfg_r},
						avs_writedata_i, avs_byteenable_i));
				end
				default: begin
				end
			endcase
		end
	end

	// Readback; unmapped offsets read zero and ignore writes
	always_comb begin
		unique case (avs_address_i)
			svm_pkg::OFS_CTRL:     rd_nxt = {31'h0000_0000, phase_direction_cfg_r};
			svm_pkg::OFS_PPR:      rd_nxt = {16'h0000, pulses_per_rev_cfg_r};
			svm_pkg::OFS_AT_RANGE: rd_nxt = at_target_range_cfg_r;
			svm_pkg::OFS_CM_RANGE: rd_nxt = coarse_match_range_cfg_r;
			svm_pkg::OFS_TQ_FWD:   rd_nxt = {16'h0000, fwd_torque_limit_cfg_r};
			svm_pkg::OFS_TQ_REV:   rd_nxt = {16'h0000, rev_torque_limit_cfg_r};
			svm_pkg::OFS_TQ_INT2:  rd_nxt = {16'h0000, internal_torque_limit2_cfg_r};
			svm_pkg::OFS_STATUS:   rd_nxt = {25'h000_0000, status};
			svm_pkg::OFS_REV_POS:  rd_nxt = rev_pos_r[31:0];
			default:               rd_nxt = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			avs_readdata_o <= 32'h0000_0000;
		end else if (bus_req && avs_waitrequest_o) begin
			avs_readdata_o <= avs_read_i ? rd_nxt : 32'h0000_0000;
		end
	end

	// Start acceptance
	svm_pkg::svm_state_t state_r;
	logic                idle_go;
	logic                any_rise;
	logic                flags_force_r;

	// A level already high when power comes up never makes an edge
	assign idle_go  = (state_r == svm_pkg::SVM_IDLE) & ~abort & mains_ok;
	assign any_rise = din.rise[svm_pkg::DIN_FWD] | din.rise[svm_pkg::DIN_REV];

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			state_r <= svm_pkg::SVM_IDLE;
		end else begin
			unique case (state_r)
				svm_pkg::SVM_IDLE: begin
					if (abort) begin
						state_r <= svm_pkg::SVM_HALTED;
					end else if (idle_go && any_rise) begin
						state_r <= svm_pkg::SVM_MOVING;
					end
				end
				svm_pkg::SVM_MOVING: begin
					// Start edges are not looked at here
					if (abort) begin
						state_r <= svm_pkg::SVM_HALTED;
					end else if (cmd_done_i) begin
						state_r <= svm_pkg::SVM_IDLE;
					end
				end
				svm_pkg::SVM_HALTED: begin
					if (!abort) begin
						state_r <= svm_pkg::SVM_IDLE;
					end
				end
			endcase
		end
	end

	// Few cycles from pin to command, far inside the allowed delay
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			move_start_fwd_o <= 1'b0;
			move_start_rev_o <= 1'b0;
			pause_resume_o   <= 1'b0;
		end else begin
			move_start_fwd_o <= idle_go & din.rise[svm_pkg::DIN_FWD];
			// Forward wins a tie; the reverse edge is dropped
			move_start_rev_o <= idle_go & din.rise[svm_pkg::DIN_REV] & ~din.rise[svm_pkg::DIN_FWD];
			pause_resume_o   <= (state_r == svm_pkg::SVM_MOVING) & din.rise[svm_pkg::DIN_PAUSE];
		end
	end

	// Flags forced on once a halt clears, until the next accepted start
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			flags_force_r <= 1'b0;
		end else if ((state_r == svm_pkg::SVM_HALTED) && !abort) begin
			flags_force_r <= 1'b1;
		end else if (idle_go && any_rise) begin
			flags_force_r <= 1'b0;
		end
	end

	function automatic logic [31:0] span(input logic [31:0] x, input logic [31:0] y);
		return (x >= y) ? (x - y) : (y - x);
	endfunction

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			motion_finished_out_o <= 1'b0;
			coarse_match_out_o    <= 1'b0;
			at_target_flag_o      <= 1'b0;
		end else begin
			motion_finished_out_o <= servo_on & (flags_force_r | (cmd_done_i &
				(span(pos_cmd_i, pos_fb_i) <= at_target_range_cfg_r)));
			coarse_match_out_o    <= servo_on & (flags_force_r |
				(span(pos_target_i, pos_cmd_i) <= coarse_match_range_cfg_r));
			at_target_flag_o      <= servo_on & (flags_force_r |
				(span(pos_target_i, pos_fb_i) <= at_target_range_cfg_r));
		end
	end

	// Torque clamp; demand is a magnitude, its sign follows the direction input
	logic [15:0] lim_base;
	logic [15:0] lim_act;
	logic        tsel;
	assign tsel     = din.level[svm_pkg::DIN_TSEL];
	assign lim_base = fb_dir_ccw_i ? fwd_torque_limit_cfg_r : rev_torque_limit_cfg_r;
	assign lim_act  = (tsel && (internal_torque_limit2_cfg_r < lim_base)) ?
		internal_torque_limit2_cfg_r : lim_base;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			torque_out_o          <= 16'h0000;
			torque_limiting_out_o <= 1'b0;
		end else begin
			torque_out_o          <= (torque_demand_i > lim_act) ? lim_act : torque_demand_i;
			torque_limiting_out_o <= (torque_demand_i >= lim_act);
		end
	end

	// Encoder emulation: four edges per output pulse
	logic [33:0] acc_r;
	logic [17:0] acc_inc;
	logic        acc_due;
	logic        quad_up;
	logic [1:0]  quad_r;
	logic [1:0]  quad_nxt;
	logic [32:0] rev_pos_nxt;
	logic        rev_wrap;
	logic [31:0] idx_cnt_r;
	logic [31:0] idx_nxt;

	assign acc_inc = {pulses_per_rev_cfg_r, 2'b00};
	assign acc_due = (acc_r >= {1'b0, FB_CNT});
	assign quad_up = fb_dir_ccw_i ^ phase_direction_cfg_r;

	// One edge per clock at most; a backlog drains over the next clocks
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			acc_r <= 34'h0_0000_0000;
		end else begin
			acc_r <= acc_r - (acc_due ? {1'b0, FB_CNT} : 34'h0_0000_0000)
				+ (fb_step_i ? {16'h0000, acc_inc} : 34'h0_0000_0000);
		end
	end

	always_comb begin
		quad_nxt = quad_r;
		if (acc_due) begin
			quad_nxt = quad_up ? (quad_r + 2'h1) : (quad_r - 2'h1);
		end
	end

	always_comb begin
		rev_pos_nxt = rev_pos_r;
		if (fb_step_i) begin
			if (fb_dir_ccw_i) begin
				rev_pos_nxt = (rev_pos_r == (FB_CNT - 33'h1)) ? 33'h0 : (rev_pos_r + 33'h1);
			end else begin
				rev_pos_nxt = (rev_pos_r == 33'h0) ? (FB_CNT - 33'h1) : (rev_pos_r - 33'h1);
			end
		end
	end

	assign rev_wrap = fb_step_i & (rev_pos_nxt == 33'h0);

	always_comb begin
		idx_nxt = 32'h0000_0000;
		if (rev_wrap) begin
			idx_nxt = IDX_LOAD;
		end else if (idx_cnt_r != 32'h0000_0000) begin
			idx_nxt = idx_cnt_r - 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			quad_r            <= 2'h0;
			rev_pos_r         <= 33'h0;
			idx_cnt_r         <= 32'h0000_0000;
			enc_phase_a_pos_o <= 1'b0;
			enc_phase_a_neg_o <= 1'b1;
			enc_phase_b_pos_o <= 1'b0;
			enc_phase_b_neg_o <= 1'b1;
			enc_index_pos_o   <= 1'b1;
			enc_index_neg_o   <= 1'b0;
		end else begin
			quad_r            <= quad_nxt;
			rev_pos_r         <= rev_pos_nxt;
			idx_cnt_r         <= idx_nxt;
			enc_phase_a_pos_o <= quad_nxt[1] ^ quad_nxt[0];
			enc_phase_a_neg_o <= ~(quad_nxt[1] ^ quad_nxt[0]);
			enc_phase_b_pos_o <= quad_nxt[1];
			enc_phase_b_neg_o <= ~quad_nxt[1];
			// Active low, once per revolution
			enc_index_pos_o   <= (idx_nxt == 32'h0000_0000);
			enc_index_neg_o   <= (idx_nxt != 32'h0000_0000);
		end
	end

	assign status = {mains_ok, servo_on, torque_limiting_out_o,
		(state_r == svm_pkg::SVM_MOVING), at_target_flag_o, coarse_match_out_o,
		motion_finished_out_o};
endmodule // svm_motion_io
`default_nettype wire

// ===== tb/svm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module svm_host_model #(
	parameter int HOLD_CYC = 600000
) (
	// Clock and bench request
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	input  wire logic go_i,
	input  wire logic rev_i,
	input  wire logic force_i,
	input  wire logic ready_i,
	// Start commands
	output logic      fwd_o,
	output logic      rev_o
);
	int hold_r;
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			hold_r <= 0;
			fwd_o  <= 1'h0;
			rev_o  <= 1'h0;
		end else if (hold_r > 1) begin
			hold_r <= hold_r - 1;
		end else if (go_i && (ready_i || force_i)) begin
			hold_r <= HOLD_CYC;
			fwd_o  <= !rev_i;
			rev_o  <= rev_i;
		end else begin
			hold_r <= 0;
			fwd_o  <= 1'h0;
			rev_o  <= 1'h0;
		end
	end
endmodule // svm_host_model
`default_nettype wire

// ===== tb/svm_motion_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module svm_motion_monitor #(
	parameter int INDEX_CYCLES = 40000
) (
	// Clock, reset and inputs
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic forward_start_cmd_i,
	input wire logic main_power_ok_i,
	input wire logic servo_on_i,
	// Outputs
	input wire logic move_start_fwd_o,
	input wire logic enc_phase_a_pos_o,
	input wire logic enc_phase_a_neg_o,
	input wire logic enc_phase_b_pos_o,
	input wire logic enc_phase_b_neg_o,
	input wire logic enc_index_pos_o,
	input wire logic enc_index_neg_o,
	input wire logic motion_finished_out_o
);
	localparam int START_MAX = svm_pkg::START_MAX_CYC;
	int lo_cnt = 0;
	int on_cnt = 0;
	// on_cnt saturates, so a long hold never wraps
	always_ff @(posedge clk_sys_i) begin
		lo_cnt <= enc_index_pos_o ? 0 : lo_cnt + 1;
		on_cnt <= !forward_start_cmd_i ? 0 : on_cnt + int'(on_cnt < 1000000);
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	chk_a_pair: assert property (enc_phase_a_neg_o == !enc_phase_a_pos_o)
		else $error("phase a pair not complementary");
	chk_b_pair: assert property (enc_phase_b_neg_o == !enc_phase_b_pos_o)
		else $error("phase b pair not complementary");
	chk_index_pair: assert property (enc_index_neg_o == !enc_index_pos_o)
		else $error("index pair not complementary");
	chk_quad_step: assert property (
		!($changed(enc_phase_a_pos_o) && $changed(enc_phase_b_pos_o)))
		else $error("both phases moved at once");
	chk_index_width: assert property ($rose(enc_index_pos_o) |-> lo_cnt >= INDEX_CYCLES - 1)
		else $error("index pulse too short");
	chk_start_power: assert property (move_start_fwd_o |-> main_power_ok_i)
		else $error("start without main power");
	chk_start_delay: assert property (
		$rose(move_start_fwd_o) |-> on_cnt inside {[1:START_MAX]})
		else $error("start not tied to a held command");
	chk_finish_servo: assert property ((!servo_on_i) [*8] |-> !motion_finished_out_o)
		else $error("finished flag while servo off");
	cover property ($rose(move_start_fwd_o));
	cover property ($fell(enc_index_pos_o));
	cover property ($rose(motion_finished_out_o));
endmodule // svm_motion_monitor
bind svm_motion_io svm_motion_monitor #(.INDEX_CYCLES(INDEX_CYCLES)) mon (.clk_sys_i, .rst_i,
	.forward_start_cmd_i, .main_power_ok_i, .servo_on_i, .move_start_fwd_o, .enc_phase_a_pos_o,
	.enc_phase_a_neg_o, .enc_phase_b_pos_o, .enc_phase_b_neg_o, .enc_index_pos_o,
	.enc_index_neg_o, .motion_finished_out_o);
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clk_sys_i = 1'h0, rst_i = 1'h1, avs_read_i = 1'h0, avs_write_i = 1'h0;
	logic [5:0]  avs_address_i = 6'h00;
	logic [3:0]  avs_byteenable_i = 4'hF;
	logic [31:0] avs_writedata_i = 32'h0, pos_cmd_i = 32'h0, pos_target_i = 32'h0;
	logic [31:0] pos_fb_i = 32'h0, avs_readdata_o, q;
	logic [15:0] torque_demand_i = 16'h0, torque_out_o;
	logic        pause_resume_cmd_i = 1'h0, emergency_halt_in_i = 1'h0, alarm_i = 1'h0;
	logic        torque_limit_select_in_i = 1'h0, main_power_ok_i = 1'h0, servo_on_i = 1'h1;
	logic        fb_step_i = 1'h0, fb_dir_ccw_i = 1'h1, cmd_done_i = 1'h0, expb = 1'h0;
	logic        go = 1'h0, go_rev = 1'h0, force_go = 1'h0, pa, pz, pf, pr;
	logic        forward_start_cmd_i, reverse_start_cmd_i, avs_waitrequest_o, at_target_flag_o;
	logic        move_start_fwd_o, move_start_rev_o, enc_phase_a_pos_o, enc_phase_b_pos_o;
	logic        enc_index_pos_o, motion_finished_out_o, coarse_match_out_o, torque_limiting_out_o;
	int          na, nb, nz, nf, nr, fail_count, compares;
	svm_motion_io #(.FB_COUNTS_PER_REV(64), .INDEX_CYCLES(20)) dut (
		.clk_sys_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
		.avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .forward_start_cmd_i,
		.reverse_start_cmd_i, .pause_resume_cmd_i, .torque_limit_select_in_i, .alarm_i,
		.emergency_halt_in_i, .main_power_ok_i, .servo_on_i, .fb_step_i, .fb_dir_ccw_i,
		.pos_cmd_i, .pos_target_i, .pos_fb_i, .cmd_done_i, .torque_demand_i, .move_start_fwd_o,
		.move_start_rev_o, .pause_resume_o(), .torque_out_o, .enc_phase_a_pos_o,
		.enc_phase_a_neg_o(), .enc_phase_b_pos_o, .enc_phase_b_neg_o(), .enc_index_pos_o,
		.enc_index_neg_o(), .motion_finished_out_o, .coarse_match_out_o, .at_target_flag_o,
		.torque_limiting_out_o);
	svm_host_model #(.HOLD_CYC(50)) host (.clk_sys_i, .rst_i, .go_i(go), .rev_i(go_rev),
		.force_i(force_go), .ready_i(main_power_ok_i), .fwd_o(forward_start_cmd_i),
		.rev_o(reverse_start_cmd_i));
	always #5 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		pa <= enc_phase_a_pos_o;
		pz <= enc_index_pos_o;
		pf <= move_start_fwd_o;
		pr <= move_start_rev_o;
		nz += int'(pz && !enc_index_pos_o);
		nf += int'(!pf && move_start_fwd_o);
		nr += int'(!pr && move_start_rev_o);
		na += int'(!pa && enc_phase_a_pos_o);
		nb += int'(!pa && enc_phase_a_pos_o && enc_phase_b_pos_o !== expb);
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		avs_address_i   <= a;
		avs_writedata_i <= d;
		avs_write_i     <= w;
		avs_read_i      <= !w;
		@(posedge clk_sys_i iff avs_waitrequest_o === 1'h0);
		q = avs_readdata_o;
		avs_write_i <= 1'h0;
		avs_read_i  <= 1'h0;
	endtask
	task automatic start(input logic r, input logic f);
		@(posedge clk_sys_i);
		go       <= 1'h1;
		go_rev   <= r;
		force_go <= f;
		@(posedge clk_sys_i);
		go <= 1'h0;
		repeat (100) @(posedge clk_sys_i);
	endtask
	task automatic give_verdict;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		fail_count++;
		give_verdict();
	end
	initial begin
		repeat (2) @(posedge clk_sys_i);
		rst_i <= 1'h0;
		bus(1'h0, svm_pkg::OFS_AT_RANGE, 32'h0);
		chk(q, svm_pkg::AT_RANGE_RST);
		bus(1'h0, svm_pkg::OFS_CM_RANGE, 32'h0);
		chk(q, svm_pkg::CM_RANGE_RST);
		bus(1'h0, 6'h3C, 32'h0);
		chk(q, 32'h0); // unmapped offset reads zero
		$display("test registers done");
		start(1'h0, 1'h1);
		chk(nf, 32'h0);
		main_power_ok_i <= 1'h1;
		start(1'h0, 1'h0);
		chk(nf, 32'h1);
		start(1'h1, 1'h1);
		chk(nr, 32'h0);
		pos_cmd_i    <= 32'h64;
		pos_target_i <= 32'h64;
		pos_fb_i     <= 32'h64;
		cmd_done_i   <= 1'h1;
		repeat (20) @(posedge clk_sys_i);
		chk({motion_finished_out_o, coarse_match_out_o, at_target_flag_o}, 32'h7);
		start(1'h1, 1'h0);
		chk(nr, 32'h1);
		servo_on_i <= 1'h0;
		repeat (20) @(posedge clk_sys_i);
		chk({motion_finished_out_o, coarse_match_out_o}, 32'h0);
		servo_on_i <= 1'h1;
		repeat (20) @(posedge clk_sys_i);
		chk({motion_finished_out_o, coarse_match_out_o, at_target_flag_o}, 32'h7);
		$display("test starts and flags done");
		bus(1'h1, svm_pkg::OFS_TQ_FWD, 32'h100);
		bus(1'h1, svm_pkg::OFS_TQ_REV, 32'h100);
		bus(1'h1, svm_pkg::OFS_TQ_INT2, 32'h80);
		torque_demand_i <= 16'h200;
		repeat (10) @(posedge clk_sys_i);
		chk({torque_limiting_out_o, torque_out_o}, 32'h10100);
		torque_limit_select_in_i <= 1'h1;
		repeat (10) @(posedge clk_sys_i);
		chk(torque_out_o, 32'h80);
		torque_demand_i <= 16'h40;
		repeat (10) @(posedge clk_sys_i);
		chk({torque_limiting_out_o, torque_out_o}, 32'h40);
		$display("test torque done");
		bus(1'h1, svm_pkg::OFS_PPR, 32'h4);
		for (int d = 0; d < 2; d++) begin
			bus(1'h1, svm_pkg::OFS_CTRL, d);
			expb = d[0];
			// Warm-up steps, then a window of exactly two revolutions
			for (int i = 0; i < 160; i++) begin
				if (i == 32) begin
					na = 0;
					nb = 0;
					nz = 0;
				end
				fb_step_i <= 1'h1;
				@(posedge clk_sys_i);
				fb_step_i <= 1'h0;
				repeat (15) @(posedge clk_sys_i);
			end
			chk(na, 32'h8);
			chk(nz, 32'h2);
			chk(nb, 32'h0);
		end
		$display("test encoder done");
		give_verdict();
	end
endmodule // tb_top
`default_nettype wire
